/* File: spi_master_slave_port.sv */
// Summary of operation
// R1 - one 8-bit shift register, full duplex
// R2 - data write loads shift or holding buffer
// R3 - data read returns first or second buffer
// R4 - master generates and drives serial clock
// R5 - slave synchronises incoming clock, shifts on edges
// R6 - master lowers select, then clocks the byte (ss_out stays tied high; the port never lowers select)
// R7 - master to slave on mosi, back on miso
// R8 - role forces pin directions to input
// R9 - output pins carry the port's values
// R10 - slave miso driven only while select low
// R11 - debugger halt freezes the port
// R12 - software sets enable bit last
// R13 - divider and doubling bit set master rate
// R14 - seven rates, fastest half the clock
// R15 - bit order chooses lsb or msb first
// R16 - select ignore removes multi-master select
// R17 - keeps running during idle sleep
// R18 - master write starts byte, flag at end
// R19 - low select demotes master, sets flag
// R20 - early unbuffered write sets collision flag
// R21 - buffered complete flag when all empty
// R22 - mode field sets polarity and phase
// R23 - disabled port releases pins, ignores lines
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"

module spi_master_slave_port
    import spi_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [2:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic dbg_halt,
    input wire logic dir_mosi,
    input wire logic dir_miso,
    input wire logic dir_sck,
    input wire logic dir_ss,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic ss_n_in,
    output logic ss_out,
    output logic ss_oe_n
);

    spi_state_type state_ff; // registered state
    spi_state_type nxt_state; // next state
    logic cpol; // clock idle level
    logic cpha; // sample on trailing edge
    logic [6:0] half_cnt; // half serial period in cycles
    logic edge_now; // a serial clock edge this cycle
    logic lead; // the edge leaves the idle level
    logic sample_now; // the edge samples input
    logic in_bit; // incoming serial bit
    logic done; // byte finished this cycle
    logic active; // transfer under way
    logic [7:0] cap; // finished received byte

    // mode field gives polarity and phase alike for both roles
    assign cpol = state_ff.xfer_mode[1]; // R22
    assign cpha = state_ff.xfer_mode[0]; // R22

    // first bit of a byte by bit order
    function automatic logic first_bit(input logic lsb_first, input logic [7:0] b);
        first_bit = lsb_first ? b[0] : b[7]; // R15
    endfunction

    // divider and doubling bit pick one of seven half periods
    always_comb begin
        unique case ({state_ff.rate_double, state_ff.rate_divider}) // R13 R14
            3'h0: half_cnt = `HALF_DIV4;
            3'h1: half_cnt = `HALF_DIV16;
            3'h2: half_cnt = `HALF_DIV64;
            3'h3: half_cnt = `HALF_DIV128;
            3'h4: half_cnt = `HALF_DIV2;
            3'h5: half_cnt = `HALF_DIV8;
            3'h6: half_cnt = `HALF_DIV32;
            3'h7: half_cnt = `HALF_DIV64;
        endcase
    end

    // next state: syncs, register access, shift engine, buffers, flags
    always_comb begin
        nxt_state = state_ff;
        edge_now = 1'b0;
        lead = 1'b0;
        sample_now = 1'b0;
        done = 1'b0;
        cap = 8'h00;
        in_bit = state_ff.master ? miso_in : mosi_in; // R7
        active = state_ff.master ? (state_ff.phase == XFER_RUN) : (state_ff.bit_cnt != 4'h0);
        nxt_state.rd_data = 8'h00;
        // two-flop synchronisers plus one edge stage
        nxt_state.sck_s1 = sck_in; // R5
        nxt_state.sck_s2 = state_ff.sck_s1;
        nxt_state.sck_s3 = state_ff.sck_s2;
        nxt_state.ss_s1 = ss_n_in;
        nxt_state.ss_s2 = state_ff.ss_s1;
        // control writes; enable is meant to be set last by software
        if (wr_stb && addr == `ADDR_CONTROL_FIRST) begin // R12
            nxt_state.enable = wr_data[`CF_ENABLE];
            nxt_state.rate_divider = wr_data[`CF_RATE_DIV_HI:`CF_RATE_DIV_LO]; // R13
            nxt_state.rate_double = wr_data[`CF_RATE_DOUBLE];
            nxt_state.master = wr_data[`CF_MASTER];
            nxt_state.bit_order = wr_data[`CF_BIT_ORDER];
        end
        if (wr_stb && addr == `ADDR_CONTROL_SECOND) begin
            nxt_state.xfer_mode = wr_data[`CS_MODE_HI:`CS_MODE_LO];
            nxt_state.select_pin_ignore = wr_data[`CS_SELECT_IGNORE];
            nxt_state.buffer_first_write_mode = wr_data[`CS_BUF_FIRST_WRITE];
            nxt_state.buffered_operation = wr_data[`CS_BUFFERED];
        end
        // flag clear by writing one; later sets override it
        if (wr_stb && addr == `ADDR_INTERRUPT_FLAGS) begin
            if (wr_data[`IF_TRANSFER]) begin
                nxt_state.if_flag = 1'b0;
            end
            if (wr_data[`IF_WRITE_COLLISION]) begin
                nxt_state.write_collision_flag = 1'b0;
            end
            if (wr_data[`IF_TRANSFER_COMPLETE]) begin
                nxt_state.transfer_complete_flag = 1'b0;
            end
        end
        // register reads, answered in the next cycle only
        if (rd_stb) begin
            unique case (addr)
                `ADDR_CONTROL_FIRST: begin
                    nxt_state.rd_data = {1'b0, state_ff.bit_order, state_ff.master,
                        state_ff.rate_double, 1'b0, state_ff.rate_divider, state_ff.enable};
                end
                `ADDR_CONTROL_SECOND: begin
                    nxt_state.rd_data = {state_ff.buffered_operation,
                        state_ff.buffer_first_write_mode, 3'h0,
                        state_ff.select_pin_ignore, state_ff.xfer_mode};
                end
                `ADDR_INTERRUPT_FLAGS: begin
                    nxt_state.rd_data = {state_ff.if_flag, state_ff.write_collision_flag,
                        state_ff.transfer_complete_flag, ~state_ff.tx_valid, 4'h0};
                end
                `ADDR_DATA: begin
                    if (state_ff.buffered_operation) begin
                        nxt_state.rd_data = state_ff.rx_second; // R3
                        // pop the receive fifo head
                        if (state_ff.rx_cnt == 2'h2) begin
                            nxt_state.rx_second = state_ff.rx_first;
                        end
                        if (state_ff.rx_cnt != 2'h0) begin
                            nxt_state.rx_cnt = state_ff.rx_cnt - 2'h1;
                        end
                    end else begin
                        nxt_state.rd_data = state_ff.rx_first; // R3
                    end
                end
                default: begin
                    nxt_state.rd_data = 8'h00;
                end
            endcase
        end
        // shift engine; nothing moves while disabled or halted (idle sleep keeps it)
        if (!state_ff.enable) begin // R23
            nxt_state.phase = XFER_IDLE;
            nxt_state.bit_cnt = 4'h0;
            nxt_state.edge_cnt = 5'h00;
            nxt_state.sck_lvl = cpol;
        end else if (!dbg_halt) begin // R11 R17
            // idle clock follows the mode field at once, so no stale level shows
            if (state_ff.phase == XFER_IDLE) begin // R22
                nxt_state.sck_lvl = nxt_state.xfer_mode[1];
            end
            if (state_ff.master && !state_ff.select_pin_ignore && !dir_ss
                && !state_ff.ss_s2) begin
                // another master owns the bus: drop to slave
                nxt_state.master = 1'b0; // R19 R16
                nxt_state.phase = XFER_IDLE;
                nxt_state.bit_cnt = 4'h0;
                nxt_state.edge_cnt = 5'h00;
                nxt_state.sck_lvl = cpol;
                nxt_state.if_flag = 1'b1; // R19
            end else if (state_ff.master) begin
                // clock generator paces the exchange
                if (state_ff.phase == XFER_RUN) begin // R4
                    if (state_ff.div_cnt == half_cnt - 7'h01) begin
                        nxt_state.div_cnt = 7'h00;
                        nxt_state.sck_lvl = ~state_ff.sck_lvl; // R4
                        nxt_state.edge_cnt = state_ff.edge_cnt + 5'h01;
                        edge_now = 1'b1;
                        lead = ~state_ff.edge_cnt[0];
                        done = (state_ff.edge_cnt == `LAST_EDGE); // R18
                    end else begin
                        nxt_state.div_cnt = state_ff.div_cnt + 7'h01;
                    end
                end
            end else if (state_ff.ss_s2) begin
                // deselected slave drops any partial byte
                nxt_state.bit_cnt = 4'h0;
            end else if (state_ff.sck_s2 != state_ff.sck_s3) begin
                edge_now = 1'b1; // R5
                lead = (state_ff.sck_s2 != cpol);
            end
            sample_now = edge_now && (lead ^ cpha); // R22
            if (sample_now) begin
                // one bit in, one bit moves toward the output
                nxt_state.shift = state_ff.bit_order ? {in_bit, state_ff.shift[7:1]}
                                                     : {state_ff.shift[6:0], in_bit}; // R1 R15
                nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
                if (!state_ff.master && state_ff.bit_cnt == `LAST_BIT) begin
                    done = 1'b1;
                    nxt_state.bit_cnt = 4'h0;
                end
            end else if (edge_now) begin
                nxt_state.out_bit = first_bit(state_ff.bit_order, state_ff.shift); // R1
            end else if (!state_ff.master && state_ff.bit_cnt == 4'h0) begin
                // idle slave presents its first bit ahead of the clock
                nxt_state.out_bit = first_bit(state_ff.bit_order, state_ff.shift);
            end
        end
        // byte finished: deliver received data and refill
        if (done) begin
            cap = nxt_state.shift;
            nxt_state.phase = XFER_IDLE;
            nxt_state.bit_cnt = 4'h0;
            nxt_state.edge_cnt = 5'h00;
            nxt_state.if_flag = 1'b1; // R18
            if (!state_ff.buffered_operation) begin
                nxt_state.rx_first = cap;
            end else begin
                // push into the two-entry receive fifo, oldest lost when full
                unique case (nxt_state.rx_cnt)
                    2'h0: begin
                        nxt_state.rx_second = cap;
                        nxt_state.rx_cnt = 2'h1;
                    end
                    2'h1: begin
                        nxt_state.rx_first = cap;
                        nxt_state.rx_cnt = 2'h2;
                    end
                    default: begin
                        nxt_state.rx_second = state_ff.rx_first;
                        nxt_state.rx_first = cap;
                    end
                endcase
                if (state_ff.tx_valid) begin
                    nxt_state.shift = state_ff.tx_hold;
                    nxt_state.tx_valid = 1'b0;
                    // a trailing-edge phase presents the bit at the next leading edge
                    if (!cpha) begin
                        nxt_state.out_bit = first_bit(state_ff.bit_order, state_ff.tx_hold);
                    end
                    if (state_ff.master) begin
                        nxt_state.phase = XFER_RUN;
                        nxt_state.div_cnt = 7'h00;
                    end
                end else begin
                    nxt_state.transfer_complete_flag = 1'b1; // R21
                end
            end
        end
        // data write: shift register, holding buffer or collision
        if (wr_stb && addr == `ADDR_DATA) begin
            if (!state_ff.buffered_operation) begin
                nxt_state.shift = wr_data; // R2
                if (active) begin
                    nxt_state.write_collision_flag = 1'b1; // R20
                end else if (state_ff.master && state_ff.enable) begin
                    nxt_state.phase = XFER_RUN; // R18
                    nxt_state.div_cnt = 7'h00;
                    nxt_state.edge_cnt = 5'h00;
                    nxt_state.bit_cnt = 4'h0;
                    nxt_state.sck_lvl = cpol;
                    nxt_state.out_bit = first_bit(state_ff.bit_order, wr_data);
                end
            end else if (state_ff.master && state_ff.enable && (!active || done)
                && !state_ff.tx_valid) begin
                // first buffered write goes out at once
                nxt_state.shift = wr_data; // R2
                nxt_state.phase = XFER_RUN;
                nxt_state.div_cnt = 7'h00;
                nxt_state.edge_cnt = 5'h00;
                nxt_state.bit_cnt = 4'h0;
                nxt_state.sck_lvl = cpol;
                nxt_state.out_bit = first_bit(state_ff.bit_order, wr_data);
            end else if (!state_ff.master && !active && state_ff.buffer_first_write_mode) begin
                nxt_state.shift = wr_data;
            end else begin
                nxt_state.tx_hold = wr_data; // R2
                nxt_state.tx_valid = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // pins: role overrides direction, user pins carry the port's values
    assign rd_data = state_ff.rd_data;
    assign mosi_out = state_ff.out_bit; // R9 R7
    assign miso_out = state_ff.out_bit; // R9 R7
    assign sck_out = state_ff.sck_lvl; // R4 R9
    assign ss_out = 1'b1;
    assign mosi_oe_n = ~(state_ff.enable && state_ff.master && dir_mosi); // R8 R23
    assign sck_oe_n = ~(state_ff.enable && state_ff.master && dir_sck); // R8 R23
    assign ss_oe_n = ~(state_ff.enable && state_ff.master && dir_ss); // R8 R23
    assign miso_oe_n = ~(state_ff.enable && !state_ff.master && dir_miso && !ss_n_in); // R8 R10

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_slave_pins_in: assert property (state_ff.enable && !state_ff.master // R8
        |-> mosi_oe_n && sck_oe_n && ss_oe_n) else $error("slave drives a master pin");
    a_master_miso_in: assert property (state_ff.enable && state_ff.master // R8
        |-> miso_oe_n) else $error("master drives miso");
    a_miso_tristate: assert property (ss_n_in |-> miso_oe_n) // R10
        else $error("miso driven while deselected");
    a_disabled_release: assert property (!state_ff.enable // R23
        |-> mosi_oe_n && miso_oe_n && sck_oe_n && ss_oe_n) else $error("disabled port drives");
    a_master_demote: assert property (state_ff.enable && state_ff.master && !dbg_halt // R19
        && !state_ff.select_pin_ignore && !dir_ss && !state_ff.ss_s2
        |=> !state_ff.master && state_ff.if_flag) else $error("select low did not demote");
    a_write_collision: assert property (wr_stb && addr == `ADDR_DATA // R20
        && !state_ff.buffered_operation && active |=> state_ff.write_collision_flag)
        else $error("collision not flagged");
    a_master_byte_len: assert property (state_ff.master && state_ff.enable // R18
        && !state_ff.buffered_operation && state_ff.phase == XFER_IDLE && !dbg_halt
        && wr_stb && addr == `ADDR_DATA && half_cnt == 7'h01 ##1 !dbg_halt [*8]
        |-> !state_ff.if_flag || $past(state_ff.if_flag, 8) || state_ff.phase == XFER_RUN)
        else $error("byte ended early");
    a_idle_clock_level: assert property (state_ff.enable && state_ff.phase == XFER_IDLE // R22
        && $past(state_ff.phase) == XFER_IDLE && $past(state_ff.enable) |-> sck_out == cpol)
        else $error("serial clock not idle");
    a_halt_freeze: assert property (dbg_halt && !wr_stb // R11
        |=> $stable(state_ff.shift) && $stable(state_ff.edge_cnt) && $stable(state_ff.sck_lvl))
        else $error("engine moved while halted");
    a_unbuf_read: assert property (rd_stb && addr == `ADDR_DATA // R3
        && !state_ff.buffered_operation |=> rd_data == $past(state_ff.rx_first))
        else $error("wrong receive buffer read");
    a_buf_complete: assert property (done && state_ff.buffered_operation // R21
        && !state_ff.tx_valid |=> state_ff.transfer_complete_flag)
        else $error("complete flag missing");

    c_master_byte: cover property (done && state_ff.master);
    c_slave_byte: cover property (done && !state_ff.master);
    c_demotion: cover property (state_ff.master ##1 !state_ff.master && state_ff.if_flag);
    c_buffer_chain: cover property (done && state_ff.tx_valid && state_ff.master);

endmodule
`default_nettype wire

/* File: spi_master_slave_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"
module spi_master_slave_port_test;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00, ptx = 8'h00, sb = 8'h00, rd_data, prx, v, got;
    logic wr_stb = 1'b0, rd_stb = 1'b0, dbg_halt = 1'b0, dir = 1'b1, dir_ss = 1'b1;
    logic mosi_in = 1'b0, sck_in = 1'b0, ss_pin = 1'b1, psel_n = 1'b1, lsb = 1'b0, sck_q = 1'b0;
    logic miso_in, mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck_out, sck_oe_n, ss_out, ss_oe_n;
    logic [1:0] mode = 2'h0;
    int error_cnt = 0, total_checks = 0, cnt = 0, h_seen = 0;

    spi_master_slave_port i_dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .dbg_halt(dbg_halt), .dir_mosi(dir), .dir_miso(dir), .dir_sck(dir), .dir_ss(dir_ss),
        .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_in),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .ss_n_in(ss_pin), .ss_out(ss_out), .ss_oe_n(ss_oe_n));
    spi_remote_model i_remote (.sck(sck_out), .mosi(mosi_out), .sel_n(psel_n), .mode(mode),
        .lsb_first(lsb), .tx(ptx), .miso(miso_in), .rx(prx));

    initial forever #25 clk_sys = ~clk_sys;
    // cycles between serial clock toggles, last interval kept
    always @(posedge clk_sys) begin
        if (sck_out !== sck_q) begin
            h_seen <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
        sck_q <= sck_out;
    end
    // expected half period of the master clock
    function automatic int half_exp(logic dbl, logic [1:0] dv);
        int base[4] = '{2, 8, 32, 64};
        return dbl ? base[dv] / 2 : base[dv];
    endfunction
    task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(negedge clk_sys);
        v = rd_data;
    endtask
    // poll the flag register until one flag is up, bounded
    task automatic wait_flag(int b);
        int n = 0;
        do begin
            rd(`ADDR_INTERRUPT_FLAGS);
            n++;
        end while (v[b] !== 1'b1 && n < 3000);
        chk("flag", 8'h01, {7'h0, v[b]});
    endtask
    // configure disabled, enable last, then send one byte
    task automatic master_xfer(logic [7:0] cf, logic [7:0] d);
        wr(`ADDR_CONTROL_FIRST, cf & 8'hfe);
        wr(`ADDR_CONTROL_FIRST, cf | 8'h01);
        repeat (2) @(posedge clk_sys);
        psel_n <= 1'b0;
        wr(`ADDR_DATA, d);
        wait_flag(`IF_TRANSFER);
        psel_n <= 1'b1;
        chk("remote rx", d, prx);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #(60000 * 50);
        error_cnt++;
        stop_test();
    end

    initial begin
        void'($urandom(51));
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`ADDR_CONTROL_FIRST);
        chk("ctrl1 reset", `CONTROL_FIRST_RESET, v);
        rd(`ADDR_CONTROL_SECOND);
        chk("ctrl2 reset", `CONTROL_SECOND_RESET, v);
        wr(3'h5, 8'hff);
        rd(3'h5);
        chk("unmapped", 8'h00, v);
        chk("oe off", 8'h0f, {4'h0, mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n});
        $display("test reset done");
        // every rate, random mode, order and data
        for (int i = 0; i < 8; i++) begin
            mode <= 2'($urandom);
            lsb <= 1'($urandom);
            ptx <= 8'($urandom);
            @(posedge clk_sys);
            wr(`ADDR_CONTROL_SECOND, {6'h0, mode});
            master_xfer({1'b0, lsb, 1'b1, i[2], 1'b0, i[1:0], 1'b0}, 8'($urandom));
            chk("half", 8'(half_exp(i[2], i[1:0])), 8'(h_seen));
            chk("oe master", 8'h04, {4'h0, mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n});
            chk("ss out", 8'h01, {7'h0, ss_out});
            chk("sck idle", {7'h0, mode[1]}, {7'h0, sck_out});
            rd(`ADDR_DATA);
            chk("rx first", ptx, v);
            wr(`ADDR_INTERRUPT_FLAGS, 8'hff);
        end
        $display("test master done");
        // early second write in unbuffered mode
        wr(`ADDR_DATA, 8'h5a);
        wr(`ADDR_DATA, 8'ha5);
        wait_flag(`IF_WRITE_COLLISION);
        wait_flag(`IF_TRANSFER);
        // two bytes chained through the holding buffer
        wr(`ADDR_CONTROL_SECOND, {6'h20, mode});
        psel_n <= 1'b0;
        wr(`ADDR_DATA, 8'h3c);
        wr(`ADDR_DATA, 8'hc3);
        wait_flag(`IF_TRANSFER_COMPLETE);
        psel_n <= 1'b1;
        chk("chain rx", 8'hc3, prx);
        rd(`ADDR_DATA);
        chk("fifo head", ptx, v);
        $display("test buffer done");
        // low select on an input select pin demotes the master
        wr(`ADDR_CONTROL_SECOND, 8'h00);
        wr(`ADDR_INTERRUPT_FLAGS, 8'hff);
        dir_ss <= 1'b0;
        ss_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(`ADDR_CONTROL_FIRST);
        chk("demoted", 8'h00, {7'h0, v[`CF_MASTER]});
        wait_flag(`IF_TRANSFER);
        ss_pin <= 1'b1;
        wr(`ADDR_CONTROL_SECOND, 8'h04);
        wr(`ADDR_CONTROL_FIRST, 8'h21);
        ss_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(`ADDR_CONTROL_FIRST);
        chk("kept master", 8'h01, {7'h0, v[`CF_MASTER]});
        ss_pin <= 1'b1;
        dir_ss <= 1'b1;
        $display("test select done");
        // debugger halt freezes a slow transfer
        wr(`ADDR_CONTROL_SECOND, 8'h00);
        wr(`ADDR_CONTROL_FIRST, 8'h27);
        wr(`ADDR_INTERRUPT_FLAGS, 8'hff);
        wr(`ADDR_DATA, 8'h99);
        repeat (10) @(posedge clk_sys);
        dbg_halt <= 1'b1;
        repeat (200) @(posedge clk_sys);
        chk("halted", 8'h01, 8'(cnt > 150));
        dbg_halt <= 1'b0;
        wait_flag(`IF_TRANSFER);
        $display("test halt done");
        // slave byte, clock and data bit-banged by the bench
        wr(`ADDR_CONTROL_FIRST, 8'h00);
        wr(`ADDR_CONTROL_FIRST, 8'h01);
        sb <= 8'($urandom);
        wr(`ADDR_DATA, 8'h96);
        chk("oe slave off", 8'h0f, {4'h0, mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n});
        ss_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("oe slave on", 8'h0b, {4'h0, mosi_oe_n, miso_oe_n, sck_oe_n, ss_oe_n});
        for (int b = 7; b >= 0; b--) begin
            mosi_in <= sb[b];
            repeat (4) @(posedge clk_sys);
            got[b] = miso_out;
            sck_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            sck_in <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        ss_pin <= 1'b1;
        chk("slave tx", 8'h96, got);
        rd(`ADDR_DATA);
        chk("slave rx", sb, v);
        $display("test slave done");
        stop_test();
    end
endmodule
`default_nettype wire

/* File: spi_port_params.svh */
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// register offsets on the plain register port
`define ADDR_CONTROL_FIRST 3'h0
`define ADDR_CONTROL_SECOND 3'h1
`define ADDR_INTERRUPT_FLAGS 3'h2
`define ADDR_DATA 3'h3

// control_first field positions
`define CF_ENABLE 0
`define CF_RATE_DIV_LO 1
`define CF_RATE_DIV_HI 2
`define CF_RATE_DOUBLE 4
`define CF_MASTER 5
`define CF_BIT_ORDER 6

// control_second field positions
`define CS_MODE_LO 0
`define CS_MODE_HI 1
`define CS_SELECT_IGNORE 2
`define CS_BUF_FIRST_WRITE 6
`define CS_BUFFERED 7

// interrupt_flags field positions
`define IF_TRANSFER 7
`define IF_WRITE_COLLISION 6
`define IF_TRANSFER_COMPLETE 5
`define IF_DATA_EMPTY 4

// reset values
`define CONTROL_FIRST_RESET 8'h00
`define CONTROL_SECOND_RESET 8'h00

// serial clock half periods in peripheral clock cycles
`define HALF_DIV4 7'h02
`define HALF_DIV16 7'h08
`define HALF_DIV64 7'h20
`define HALF_DIV128 7'h40
`define HALF_DIV2 7'h01
`define HALF_DIV8 7'h04
`define HALF_DIV32 7'h10

// index of the last serial clock edge and of the last bit in one byte
`define LAST_EDGE 5'h0f
`define LAST_BIT 4'h7

`endif

/* File: spi_port_pkg.sv */
package spi_port_pkg;

    // transfer engine phase
    typedef enum logic {
        XFER_IDLE,
        XFER_RUN
    } xfer_type;

    // every flip-flop of the port
    typedef struct packed {
        logic enable;
        logic master;
        logic bit_order;
        logic rate_double;
        logic [1:0] rate_divider;
        logic buffered_operation;
        logic buffer_first_write_mode;
        logic select_pin_ignore;
        logic [1:0] xfer_mode;
        xfer_type phase;
        logic [7:0] shift;
        logic out_bit;
        logic [4:0] edge_cnt;
        logic [3:0] bit_cnt;
        logic [6:0] div_cnt;
        logic sck_lvl;
        logic [7:0] tx_hold;
        logic tx_valid;
        logic [7:0] rx_first;
        logic [7:0] rx_second;
        logic [1:0] rx_cnt;
        logic if_flag;
        logic transfer_complete_flag;
        logic write_collision_flag;
        logic [7:0] rd_data;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic ss_s1;
        logic ss_s2;
    } spi_state_type;

endpackage

/* File: spi_remote_model.sv */
`timescale 1ns/1ps
`default_nettype none
// remote serial device hanging on the far end of the serial lines
module spi_remote_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic [1:0] mode,
    input wire logic lsb_first,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    int idx = 0; // bit slot now on the return line, negative before the first shift of a trailing-edge phase
    logic last = 1'b0; // last level driven, so a released line shows its inverse
    wire live = !sel_n && idx >= 0;
    wire [2:0] pos = lsb_first ? idx[2:0] : 3'h7 - idx[2:0];
    // return data only while selected, never a stale level
    assign miso = live ? tx[pos] : ~last;
    always @(miso) if (live) last = miso;
    // a trailing-edge phase shifts on the leading edge, so start one slot early
    always @(negedge sel_n) idx = mode[0] ? -1 : 0;
    initial rx = 8'h00;
    // sample on one edge, move the return bit on the other
    always @(sck) begin
        if (!sel_n) begin
            if (sck == (mode[1] == mode[0])) begin
                rx <= lsb_first ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            end else begin
                idx++;
            end
        end
    end
endmodule
`default_nettype wire
